// ### hdl/dtb_timers.sv
// Two machine-cycle timers with four modes and a serial bit-clock output
`timescale 1ns/1ps
`default_nettype none
module dtb_timers (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst_b,
   // Mode and run control
   input  wire dtb_pkg::dtb_mode_t t0_mode,
   input  wire dtb_pkg::dtb_mode_t t1_mode,
   input  wire logic            t0_run,
   input  wire logic            t1_run,
   // Byte writes from software
   input  wire logic [7:0]      wr_data,
   input  wire logic            wr_t0_low,
   input  wire logic            wr_t0_high,
   input  wire logic            wr_t1_low,
   input  wire logic            wr_t1_high,
   // Overflow flag clears
   input  wire logic            t0_flag_clr,
   input  wire logic            t1_flag_clr,
   // Serial bit-clock selection
   input  wire logic [1:0]      uart_mode,
   input  wire logic            baud_from_timer1,
   input  wire logic            rate_doubling_select,
   // Timer contents
   output logic [7:0]           timer_zero_low_byte,
   output logic [7:0]           timer_zero_high_byte,
   output logic [7:0]           timer_one_low_byte,
   output logic [7:0]           timer_one_high_byte,
   // Overflow flags, usable as interrupt requests
   output logic                 t0_flag,
   output logic                 t1_flag,
   // One-clock bit-clock pulse for the serial port
   output logic                 baud_tick
);
   // Registers and next values
   logic       mc_q,   mc_d;     // Machine-cycle phase
   logic [7:0] lo0_q,  lo0_d;    // Timer zero low byte
   logic [7:0] hi0_q,  hi0_d;    // Timer zero high byte
   logic [7:0] lo1_q,  lo1_d;    // Timer one low byte
   logic [7:0] hi1_q,  hi1_d;    // Timer one high byte
   logic       f0_q,   f0_d;     // Timer zero overflow flag
   logic       f1_q,   f1_d;     // Timer one overflow flag
   logic [4:0] div_q,  div_d;    // Overflow divider for the bit clock
   logic       bt_q,   bt_d;     // Bit-clock pulse
   logic [16:0] s0, s1;          // {overflow, high, low} after one step
   logic       tick;             // One machine cycle elapsed
   logic       ov0, ov1;         // Wraps in this clock
   logic       ovt1;             // Timer one's own wrap, the only bit-clock source
   logic       bsel;             // Timer one drives the bit clock
   logic [4:0] blast;            // Divider end count

   // One step of a timer in modes zero to two
   function automatic logic [16:0] step(input dtb_pkg::dtb_mode_t m,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      unique case (m)
         dtb_pkg::DTB_MODE_PRESCALED: begin
            // Upper low-byte bits are left alone; only five prescale
            r[4:0] = lo[4:0] + 5'h01;
            if (lo[4:0] == dtb_pkg::PRE_LAST) begin
               r[15:8] = hi + 8'h01;
               r[16]   = (hi == 8'hff);
            end
         end
         dtb_pkg::DTB_MODE_WIDE: begin
            r = {1'b0, hi, lo} + 17'h00001;
         end
         dtb_pkg::DTB_MODE_RELOAD: begin
            // Reload comes from the software-held high byte
            r[7:0] = (lo == 8'hff) ? hi : lo + 8'h01;
            r[16]  = (lo == 8'hff);
         end
         dtb_pkg::DTB_MODE_SPLIT: begin
            // Split handling lives with the caller
            r = {1'b0, hi, lo};
         end
      endcase
      return r;
   endfunction : step

   // Next-state logic for the counters
   always_comb begin
      mc_d  = ~mc_q;
      tick  = mc_q;
      s0    = step(t0_mode, lo0_q, hi0_q);
      s1    = step(t1_mode, lo1_q, hi1_q);
      lo0_d = lo0_q;
      hi0_d = hi0_q;
      lo1_d = lo1_q;
      hi1_d = hi1_q;
      ov0   = 1'b0;
      ov1   = 1'b0;
      ovt1  = 1'b0;
      if (t0_mode == dtb_pkg::DTB_MODE_SPLIT) begin
         // Low byte under timer zero's run, high byte under timer one's
         if (tick && t0_run) begin
            lo0_d = lo0_q + 8'h01;
            ov0   = (lo0_q == 8'hff);
         end
         if (tick && t1_run) begin
            hi0_d = hi0_q + 8'h01;
            ov1   = (hi0_q == 8'hff);
         end
      end else if (tick && t0_run) begin
         {hi0_d, lo0_d} = s0[15:0];
         ov0            = s0[16];
      end
      // Timer one holds in split mode even when enabled
      if (tick && t1_run && t1_mode != dtb_pkg::DTB_MODE_SPLIT) begin
         {hi1_d, lo1_d} = s1[15:0];
         ov1            = ov1 | s1[16];
         ovt1           = s1[16];
      end
      // Software writes win over counting in the same clock
      if (wr_t0_low)  lo0_d = wr_data;
      if (wr_t0_high) hi0_d = wr_data;
      if (wr_t1_low)  lo1_d = wr_data;
      if (wr_t1_high) hi1_d = wr_data;
   end

   // Next-state logic for flags and the bit clock
   always_comb begin
      // A wrap in the clearing clock is kept
      f0_d  = ov0 | (f0_q & ~t0_flag_clr);
      f1_d  = ov1 | (f1_q & ~t1_flag_clr);
      bsel  = baud_from_timer1 &&
              (uart_mode == dtb_pkg::UART_VAR_A || uart_mode == dtb_pkg::UART_VAR_B);
      // Doubling halves the overflows per bit clock
      blast = rate_doubling_select ? dtb_pkg::BAUD_LAST_X2 : dtb_pkg::BAUD_LAST;
      div_d = div_q;
      bt_d  = 1'b0;
      if (!bsel) begin
         div_d = dtb_pkg::DIV_RST;
      end else if (ovt1) begin
         // Split-mode high byte borrows timer one's flag, never its bit clock
         if (div_q >= blast) begin
            div_d = dtb_pkg::DIV_RST;
            bt_d  = 1'b1;
         end else begin
            div_d = div_q + 5'h01;
         end
      end
   end

   // State registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mc_q  <= 1'b0;
         lo0_q <= dtb_pkg::BYTE_RST;
         hi0_q <= dtb_pkg::BYTE_RST;
         lo1_q <= dtb_pkg::BYTE_RST;
         hi1_q <= dtb_pkg::BYTE_RST;
         f0_q  <= 1'b0;
         f1_q  <= 1'b0;
         div_q <= dtb_pkg::DIV_RST;
         bt_q  <= 1'b0;
      end else begin
         mc_q  <= mc_d;
         lo0_q <= lo0_d;
         hi0_q <= hi0_d;
         lo1_q <= lo1_d;
         hi1_q <= hi1_d;
         f0_q  <= f0_d;
         f1_q  <= f1_d;
         div_q <= div_d;
         bt_q  <= bt_d;
      end
   end

   // Outputs straight from flip-flops
   assign timer_zero_low_byte  = lo0_q;
   assign timer_zero_high_byte = hi0_q;
   assign timer_one_low_byte   = lo1_q;
   assign timer_one_high_byte  = hi1_q;
   assign t0_flag              = f0_q;
   assign t1_flag              = f1_q;
   assign baud_tick            = bt_q;

   // Checks
   property p_tick_alt;
      @(posedge clk) disable iff (!rst_b) $past(rst_b) |-> (mc_q != $past(mc_q));
   endproperty
   a_tick_alt: assert property (p_tick_alt) else $error("machine cycle not every 2 clocks");

   property p_wide_inc;
      @(posedge clk) disable iff (!rst_b)
         (tick && t0_run && t0_mode == dtb_pkg::DTB_MODE_WIDE && !wr_t0_low && !wr_t0_high)
         |=> ({hi0_q, lo0_q} == $past({hi0_q, lo0_q}) + 16'h0001);
   endproperty
   a_wide_inc: assert property (p_wide_inc) else $error("16-bit count wrong");

   property p_pre_hold;
      @(posedge clk) disable iff (!rst_b)
         (tick && t0_run && t0_mode == dtb_pkg::DTB_MODE_PRESCALED && lo0_q[4:0] != 5'h1f
          && !wr_t0_high) |=> $stable(hi0_q);
   endproperty
   a_pre_hold: assert property (p_pre_hold) else $error("high byte moved before prescale wrap");

   property p_reload;
      @(posedge clk) disable iff (!rst_b)
         (tick && t0_run && t0_mode == dtb_pkg::DTB_MODE_RELOAD && lo0_q == 8'hff
          && !wr_t0_low && !wr_t0_high) |=> (lo0_q == hi0_q) && f0_q;
   endproperty
   a_reload: assert property (p_reload) else $error("reload or flag missing");

   property p_split_hi;
      @(posedge clk) disable iff (!rst_b)
         (tick && t1_run && !t0_run && t0_mode == dtb_pkg::DTB_MODE_SPLIT && !wr_t0_low
          && !wr_t0_high) |=> (hi0_q == $past(hi0_q) + 8'h01) && $stable(lo0_q);
   endproperty
   a_split_hi: assert property (p_split_hi) else $error("split bytes not independent");

   property p_t1_frozen;
      @(posedge clk) disable iff (!rst_b)
         (t1_mode == dtb_pkg::DTB_MODE_SPLIT && !wr_t1_low && !wr_t1_high)
         |=> $stable({hi1_q, lo1_q});
   endproperty
   a_t1_frozen: assert property (p_t1_frozen) else $error("timer one moved while halted");

   property p_flag_keep;
      @(posedge clk) disable iff (!rst_b) (ov0 && t0_flag_clr) |=> f0_q;
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("overflow lost on clear");

   property p_baud_off;
      @(posedge clk) disable iff (!rst_b) !bsel |=> !bt_q;
   endproperty
   a_baud_off: assert property (p_baud_off) else $error("bit clock while deselected");

   property p_baud_space;
      @(posedge clk) disable iff (!rst_b) bt_q |=> !bt_q [*1] ##0 (div_q == 5'h00);
   endproperty
   a_baud_space: assert property (p_baud_space) else $error("divider not restarted");

   c_wrap0:  cover property (@(posedge clk) disable iff (!rst_b) ov0);
   c_split:  cover property (@(posedge clk) disable iff (!rst_b)
                             t0_mode == dtb_pkg::DTB_MODE_SPLIT && ov1);
   c_baud:   cover property (@(posedge clk) disable iff (!rst_b) bt_q && rate_doubling_select);
endmodule : dtb_timers
`default_nettype wire

// ### hdl/dtb_pkg.sv
// Constants and types shared by the dual timer with serial bit-clock source
package dtb_pkg;
   // Operating modes of each timer
   typedef enum logic [1:0] {
      DTB_MODE_PRESCALED = 2'b00, // 13-bit, divide-by-32 front end
      DTB_MODE_WIDE      = 2'b01, // 16-bit counter
      DTB_MODE_RELOAD    = 2'b10, // 8-bit auto-reload
      DTB_MODE_SPLIT     = 2'b11  // Timer zero split, timer one frozen
   } dtb_mode_t;

   // Input clocks per machine cycle
   localparam int unsigned MC_CLOCKS    = 2;
   // Prescaler wrap point in mode zero (divide by 32)
   localparam logic [4:0]  PRE_LAST     = 5'h1f;
   // Divider end counts (32 and 16 overflows per bit clock), normal and doubled rate
   localparam logic [4:0]  BAUD_LAST    = 5'h1f;
   localparam logic [4:0]  BAUD_LAST_X2 = 5'h0f;
   // Serial modes that take a variable bit clock
   localparam logic [1:0]  UART_VAR_A   = 2'h1;
   localparam logic [1:0]  UART_VAR_B   = 2'h3;
   // Reset values
   localparam logic [7:0]  BYTE_RST     = 8'h00;
   localparam logic [4:0]  DIV_RST      = 5'h00;
endpackage : dtb_pkg

// ### tb/dtb_uart_model.sv
// Serial-port side model that counts and times the bit clock it receives
`timescale 1ns/1ps
`default_nettype none
module dtb_uart_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Bit clock pulse from the timers
   input  wire logic        baud_tick,
   // Pulses seen and clocks between the last two
   output logic [15:0]      ticks,
   output logic [15:0]      gap
);
   logic [15:0] since_q; // Clocks since the last pulse
   // Each pulse starts a new bit time; its spacing is kept for checking
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         since_q <= 16'h0001;
         ticks   <= 16'h0000;
         gap     <= 16'h0000;
      end else if (baud_tick) begin
         since_q <= 16'h0001;
         ticks   <= ticks + 16'h0001;
         gap     <= since_q;
      end else begin
         since_q <= since_q + 16'h0001;
      end
   end
endmodule : dtb_uart_model
`default_nettype wire

// ### tb/dual_timer_with_baud_source_bench.sv
// Self-checking bench for the dual timer and its bit-clock output
`timescale 1ns/1ps
`default_nettype none
module dual_timer_with_baud_source_bench;
   logic clk, rst_b, r0, r1, c0, c1, bs, dbl, w16, e; // Stimulus
   dtb_pkg::dtb_mode_t md0, md1; // Timer modes
   logic [7:0] wd, hb, h [2], l [2]; // Write data and expected bytes
   logic [3:0] ws; // Write strobes
   logic [1:0] um; // Serial port mode
   wire logic [3:0][7:0] q; // Timer bytes
   wire logic [1:0] f; // Overflow flags
   wire logic bt; // Bit clock pulse
   wire logic [15:0] ticks, gap; // Model results
   int err_count, num_checks, n, mm, w;
   integer seed; // Random seed
   dtb_timers dut_u (.clk(clk), .rst_b(rst_b), .t0_mode(md0), .t1_mode(md1),
      .t0_run(r0), .t1_run(r1), .wr_data(wd), .wr_t0_low(ws[0]), .wr_t0_high(ws[1]),
      .wr_t1_low(ws[2]), .wr_t1_high(ws[3]), .t0_flag_clr(c0), .t1_flag_clr(c1),
      .uart_mode(um), .baud_from_timer1(bs), .rate_doubling_select(dbl),
      .timer_zero_low_byte(q[0]), .timer_zero_high_byte(q[1]), .timer_one_low_byte(q[2]),
      .timer_one_high_byte(q[3]), .t0_flag(f[0]), .t1_flag(f[1]), .baud_tick(bt));
   dtb_uart_model uart_u (.clk(clk), .rst_b(rst_b), .baud_tick(bt), .ticks(ticks), .gap(gap));
   // Free-running 20 MHz clock
   always #25 clk = ~clk;
   // One machine cycle of a timer in modes zero to two: {wrap, high, low}
   function automatic logic [16:0] adv(input int m, input logic [7:0] hi, lo);
      logic [16:0] x;
      x = {1'b0, hi, lo} + 17'h00001;
      if (m == 2) x = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      if (m == 0) x = {{1'b0, hi} + {8'h00, lo[4:0] == 5'h1f}, lo[7:5], lo[4:0] + 5'h01};
      return x;
   endfunction : adv
   task automatic chk(input logic [15:0] g, x);
      num_checks++;
      if (g !== x) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic chk_byte(input logic [7:0] g, x);
      chk({8'h00, g}, {8'h00, x});
   endtask : chk_byte
   task automatic chk_flag(input logic g, x);
      chk({15'h0000, g}, {15'h0000, x});
   endtask : chk_flag
   task automatic wr(input int i, input logic [7:0] d); // One-cycle byte write
      @(posedge clk);
      ws[i] <= 1'b1;
      wd <= d;
      @(posedge clk);
      ws <= 4'h0;
   endtask : wr
   task automatic clr; // Clear both flags
      @(posedge clk);
      {c0, c1} <= 2'b11;
      @(posedge clk);
      {c0, c1} <= 2'b00;
   endtask : clr
   // Two clocks of run give exactly one count whatever the machine phase
   task automatic step(input logic a, b, input int k);
      @(posedge clk);
      r0 <= a;
      r1 <= b;
      repeat (2 * k) @(posedge clk);
      r0 <= 1'b0;
      r1 <= 1'b0;
      #1;
   endtask : step
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Watchdog sized well above the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      report_and_stop;
   end
   // Main sequence
   initial begin
      {clk, rst_b, r0, r1, c0, c1, bs, dbl, wd, ws, um} = '0;
      md0 = dtb_pkg::DTB_MODE_PRESCALED;
      md1 = dtb_pkg::DTB_MODE_PRESCALED;
      {err_count, num_checks} = '0;
      seed = 32'h12a6fff4;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      for (int i = 0; i < 4; i++) chk_byte(q[i], 8'h00);
      $display("Test reset done");
      // Random counts, different modes per timer, wrap corners late on
      for (int k = 0; k < 12; k++) begin
         n = 1 + ($random(seed) & 3);
         @(posedge clk);
         md0 <= dtb_pkg::dtb_mode_t'(k % 3);
         md1 <= dtb_pkg::dtb_mode_t'((k + 1) % 3);
         for (int t = 0; t < 2; t++) begin
            h[t] = (k > 8) ? 8'hff : 8'($random(seed));
            l[t] = (k > 5) ? 8'hff : 8'($random(seed));
            wr(2 * t + 1, h[t]);
            wr(2 * t, l[t]);
         end
         clr;
         step(1'b1, 1'b1, n);
         for (int t = 0; t < 2; t++) begin
            e = 1'b0;
            mm = (k + t) % 3;
            for (int i = 0; i < n; i++) begin
               {w16, h[t], l[t]} = adv(mm, h[t], l[t]);
               e = e | w16;
            end
            chk_byte(q[2 * t], l[t]);
            chk_byte(q[2 * t + 1], h[t]);
            chk_flag(f[t], e);
         end
      end
      // Reload mode with ff/ff wraps every count; a held clear must not win
      wr(1, 8'hff);
      wr(0, 8'hff);
      @(posedge clk);
      {c0, r0} <= 2'b11;
      repeat (4) @(posedge clk);
      #1;
      e = f[0];
      @(posedge clk);
      {c0, r0} <= 2'b00;
      #1;
      chk_flag(e | f[0], 1'b1);
      $display("Test modes zero to two done");
      // Split mode: two byte counters, timer one frozen
      @(posedge clk);
      md0 <= dtb_pkg::DTB_MODE_SPLIT;
      md1 <= dtb_pkg::DTB_MODE_SPLIT;
      wr(0, 8'hfe);
      wr(1, 8'hff);
      wr(2, 8'h5a);
      wr(3, 8'ha5);
      clr;
      step(1'b1, 1'b0, 2);
      chk_byte(q[0], 8'h00);
      chk_byte(q[1], 8'hff);
      chk_flag(f[0], 1'b1);
      chk_flag(f[1], 1'b0);
      step(1'b0, 1'b1, 1);
      chk_byte(q[1], 8'h00);
      chk_flag(f[1], 1'b1);
      step(1'b1, 1'b1, 3);
      chk_byte(q[2], 8'h5a);
      chk_byte(q[3], 8'ha5);
      chk_byte(q[0], 8'h03);
      chk_byte(q[1], 8'h03);
      $display("Test split mode done");
      // Bit clock from timer one in reload mode, both rates, both serial modes
      for (int k = 0; k < 4; k++) begin
         hb = 8'hf8 | 8'($random(seed));
         wr(3, hb);
         @(posedge clk);
         md1 <= dtb_pkg::DTB_MODE_RELOAD;
         um <= k[1] ? 2'h3 : 2'h1;
         dbl <= k[0];
         bs <= 1'b1;
         r1 <= 1'b1;
         #1;
         w = 0;
         n = ticks;
         while (ticks != 16'(n + 3) && w < 4000) begin
            @(posedge clk);
            #1;
            w++;
         end
         if (w >= 4000) chk(ticks, 16'(n + 3));
         chk(gap, (16'h0040 * (16'h0100 - {8'h00, hb})) >> dbl);
      end
      @(posedge clk);
      bs <= 1'b0;
      #1;
      n = ticks;
      repeat (600) @(posedge clk);
      chk(ticks, 16'(n));
      @(posedge clk);
      bs <= 1'b1;
      um <= 2'h2;
      #1;
      n = ticks;
      repeat (600) @(posedge clk);
      chk(ticks, 16'(n));
      $display("Test bit clock done");
      report_and_stop;
   end
endmodule : dual_timer_with_baud_source_bench
`default_nettype wire
